// [hw/pti_pkg.sv]
// Package for the timer interrupt-flag and status register bank
package pti_pkg;

    // Register byte offsets
    localparam logic [7:0] SYNC_BUSY_OFS = 8'h04;
    localparam logic [7:0] IRQ_EN_CLR_OFS = 8'h24;
    localparam logic [7:0] IRQ_EN_SET_OFS = 8'h28;
    localparam logic [7:0] FLAG_OFS = 8'h2c;
    localparam logic [7:0] STATUS_OFS = 8'h30;

    // Reset values
    localparam logic [31:0] FLAG_RST = 32'h0000_0000;
    localparam logic [31:0] STATUS_RST = 32'h0000_0001;
    localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;

    // Interrupt flag field positions
    localparam int FLG_OVF = 0;
    localparam int FLG_TRG = 1;
    localparam int FLG_CNT = 2;
    localparam int FLG_ERR = 3;
    localparam int FLG_UFS = 10;
    localparam int FLG_DFS = 11;
    localparam int FLG_FAULT = 12;
    localparam int FLG_MC = 16;
    localparam logic [31:0] FLAG_MASK = 32'h000f_fc0f;

    // Status field positions
    localparam int ST_STOP = 0;
    localparam int ST_IDX = 1;
    localparam int ST_UFS = 2;
    localparam int ST_DFS = 3;
    localparam int ST_BUFV = 5;
    localparam int ST_FAULT_IN = 8;
    localparam int ST_FAULT = 12;
    localparam int ST_CHANNEL_BUFFER_VALID = 16;
    localparam int ST_CMP = 24;
    localparam logic [31:0] STATUS_STORE_MASK = 32'h000f_f0ed;

    // Status crossing time and its cycle count at 250 MHz
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STATUS_SYNC_NS = 8;
    localparam int STATUS_SYNC_CYC = (STATUS_SYNC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYNC_BUSY_STATUS = 0;

    // Events and levels from the count logic, fault order {hard1, hard0, soft second, soft first}
    typedef struct packed {
        logic [3:0] cmp_match;
        logic [3:0] capture_valid;
        logic [3:0] capture_mode;
        logic [3:0] cc_read;
        logic [3:0] ccb_write;
        logic [3:0] compare_output_level;
        logic [3:0] fault_event;
        logic [1:0] soft_fault_resume;
        logic debug_fault;
        logic debug_mode;
        logic ramp_phase;
        logic lock_update;
        logic update;
        logic oneshot;
        logic stop_cmd;
        logic count_step;
        logic counter_event;
        logic retrigger;
        logic overflow;
        logic [2:0] buf_write;
    } pti_evt_t;

endpackage : pti_pkg

// [hw/pti_irq_status.sv]
// Interrupt flag, enable and status register bank of the control timer
//
// Function
// - Enable-set write one enables counter/retrigger/overflow
// - Channel flag sets after match or capture
// - Channel flag clears on write one, capture read
// - Hard fault one flag sets, write-one clears
// - Hard fault zero flag clears on write one
// - Soft fault second flag sets, write-one clears
// - Soft fault first flag write-one clears
// - Debug fault flag sets, write-one clears
// - Update fault flag: ramp change while locked
// - Error flag on capture into full channel
// - Counter event flag sets, write-one clears
// - Retrigger flag sets, write-one clears
// - Overflow flag sets, write-one clears
// - Writing zero leaves any flag unchanged
// - Flag register at its offset, resets clear
// - Status resets with only stopped bit set
// - Status bits 24-27 show compare outputs
// - Fault input status bits follow inputs
// - Capture buffer valid set, cleared on read
// - Period buffer valid set, update while locked or write clears
// - Stopped bit set on halt, cleared on step
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module pti_irq_status #(
    parameter int NUM_CH = 4,
    parameter bit EXTENDED = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire pti_pkg::pti_evt_t evt_i,
    input wire logic [3:0] fault_pin_i,
    output logic irq_o
);
    import pti_pkg::*;

    // Bit layout is fixed at four channels
    if (NUM_CH != 4) begin : g_bad_ch
        $error("pti_irq_status supports only NUM_CH = 4");
    end

    logic [31:0] flag_reg;
    logic [31:0] flag_next;
    logic [31:0] irq_en_reg;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] status_view;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [3:0] fault_meta_reg;
    logic [3:0] fault_in_reg;
    logic ramp_prev_reg;
    logic [1:0] busy_cnt_reg;
    logic [31:0] flag_set;
    logic [31:0] flag_clr;
    logic [31:0] st_set;
    logic [31:0] st_clr;
    logic setup_ph;
    logic access_wr;
    logic ramp_change;

    // Address decode for the error answer; the read mux decodes on its own
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == SYNC_BUSY_OFS) || (a == IRQ_EN_CLR_OFS) || (a == IRQ_EN_SET_OFS)
            || (a == FLAG_OFS) || (a == STATUS_OFS);
    endfunction : addr_mapped

    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        return wr && (a == ofs);
    endfunction : wr_hit

    assign setup_ph = psel_i && !penable_i;
    assign access_wr = psel_i && penable_i && pwrite_i;
    assign ramp_change = evt_i.ramp_phase != ramp_prev_reg;

    // Fault pins come from outside, two flops before use
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_meta_reg <= 4'h0;
            fault_in_reg <= 4'h0;
        end else begin
            fault_meta_reg <= fault_pin_i;
            fault_in_reg <= fault_meta_reg;
        end
    end

    // Previous ramp phase for change detection
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ramp_prev_reg <= 1'b0;
        end else begin
            ramp_prev_reg <= evt_i.ramp_phase;
        end
    end

    // Flag set and clear terms; set wins over a clear in the same cycle
    always_comb begin
        flag_set = 32'h0000_0000;
        flag_clr = 32'h0000_0000;
        flag_set[FLG_OVF] = evt_i.overflow;
        flag_set[FLG_TRG] = evt_i.retrigger;
        flag_set[FLG_CNT] = evt_i.counter_event;
        // Capture into a still-set channel has nowhere to go
        flag_set[FLG_ERR] = |(evt_i.capture_valid & flag_reg[FLG_MC +: 4]);
        flag_set[FLG_UFS] = EXTENDED && ramp_change && evt_i.lock_update;
        flag_set[FLG_DFS] = evt_i.debug_fault;
        flag_set[FLG_FAULT +: 4] = evt_i.fault_event;
        flag_set[FLG_MC +: 4] = evt_i.cmp_match | evt_i.capture_valid;
        if (wr_hit(access_wr, paddr_i, FLAG_OFS)) begin
            flag_clr = pwdata_i & FLAG_MASK;
        end
        flag_clr[FLG_MC +: 4] = flag_clr[FLG_MC +: 4]
            | (evt_i.cc_read & evt_i.capture_mode);
        flag_next = ((flag_reg & ~flag_clr) | flag_set) & FLAG_MASK;
    end

    // Flag register, all clear after reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_reg <= FLAG_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Enable register: set and clear aliases, zero writes ignored
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_reg <= IRQ_EN_RST;
        end else if (wr_hit(access_wr, paddr_i, IRQ_EN_SET_OFS)) begin
            irq_en_reg <= irq_en_reg | (pwdata_i & FLAG_MASK);
        end else if (wr_hit(access_wr, paddr_i, IRQ_EN_CLR_OFS)) begin
            irq_en_reg <= irq_en_reg & ~pwdata_i;
        end
    end

    // Request is a plain level of enabled flags
    assign irq_o = |(flag_reg & irq_en_reg);

    // Stored status bits: set and clear terms, set wins
    always_comb begin
        st_set = 32'h0000_0000;
        st_clr = 32'h0000_0000;
        st_set[ST_STOP] = evt_i.stop_cmd || (evt_i.update && evt_i.oneshot);
        st_clr[ST_STOP] = evt_i.count_step;
        st_set[ST_UFS] = EXTENDED && ramp_change && evt_i.lock_update;
        st_set[ST_DFS] = evt_i.debug_fault;
        st_set[ST_BUFV +: 3] = evt_i.buf_write;
        st_clr[ST_BUFV +: 3] = {3{evt_i.update && evt_i.lock_update}};
        st_set[ST_FAULT +: 4] = evt_i.fault_event;
        st_clr[ST_FAULT +: 2] = evt_i.soft_fault_resume;
        // Capture channels fill on capture, compare channels on buffer write
        st_set[ST_CHANNEL_BUFFER_VALID +: 4] = (evt_i.capture_valid & evt_i.capture_mode)
            | (evt_i.ccb_write & ~evt_i.capture_mode);
        st_clr[ST_CHANNEL_BUFFER_VALID +: 4] = (evt_i.cc_read & evt_i.capture_mode)
            | ({4{evt_i.update}} & ~evt_i.capture_mode);
        if (wr_hit(access_wr, paddr_i, STATUS_OFS)) begin
            st_clr[ST_UFS] = pwdata_i[ST_UFS];
            st_clr[ST_DFS] = st_clr[ST_DFS] | (pwdata_i[ST_DFS] && !evt_i.debug_mode);
            st_clr[ST_BUFV +: 3] = st_clr[ST_BUFV +: 3] | pwdata_i[ST_BUFV +: 3];
            // Write-one clears a fault state only while its input is quiet
            st_clr[ST_FAULT +: 4] = st_clr[ST_FAULT +: 4]
                | (pwdata_i[ST_FAULT +: 4] & ~fault_in_reg);
            st_clr[ST_CHANNEL_BUFFER_VALID +: 4] = st_clr[ST_CHANNEL_BUFFER_VALID +: 4]
                | (pwdata_i[ST_CHANNEL_BUFFER_VALID +: 4] & ~evt_i.capture_mode & {4{evt_i.lock_update}});
        end
        status_next = ((status_reg & ~st_clr) | st_set) & STATUS_STORE_MASK;
    end

    // Status store, only the stopped bit set out of reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // Live levels join the stored bits on read
    always_comb begin
        status_view = status_reg;
        status_view[ST_IDX] = evt_i.ramp_phase;
        status_view[ST_FAULT_IN +: 4] = fault_in_reg;
        status_view[ST_CMP +: 4] = evt_i.compare_output_level;
    end

    // Busy window after any status access, for software to poll
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt_reg <= 2'd0;
        end else if (psel_i && penable_i && (paddr_i == STATUS_OFS)) begin
            busy_cnt_reg <= 2'(STATUS_SYNC_CYC);
        end else if (busy_cnt_reg != 2'd0) begin
            busy_cnt_reg <= busy_cnt_reg - 2'd1;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            pslverr_reg <= !addr_mapped(paddr_i);
            prdata_reg <= 32'h0000_0000;
            if (!pwrite_i) begin
                case (paddr_i)
                    SYNC_BUSY_OFS: prdata_reg[SYNC_BUSY_STATUS] <= busy_cnt_reg != 2'd0;
                    IRQ_EN_CLR_OFS: prdata_reg <= irq_en_reg;
                    IRQ_EN_SET_OFS: prdata_reg <= irq_en_reg;
                    FLAG_OFS: prdata_reg <= flag_reg;
                    STATUS_OFS: prdata_reg <= status_view;
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Zero wait states: ready in the first access cycle
    assign pready_o = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && pslverr_reg;
    assign prdata_o = prdata_reg;

    // Checks of the flag and status behaviour
    sequence s_ovf_cause;
        evt_i.overflow;
    endsequence

    sequence s_flag_w1c(int b);
        wr_hit(access_wr, paddr_i, FLAG_OFS) && pwdata_i[b];
    endsequence

    AST_OVF_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_ovf_cause |=> flag_reg[FLG_OVF])
        else $error("overflow flag not set after overflow");

    AST_TRG_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.retrigger |=> flag_reg[FLG_TRG])
        else $error("retrigger flag not set");

    AST_CNT_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_flag_w1c(FLG_CNT) and !evt_i.counter_event |=> !flag_reg[FLG_CNT])
        else $error("counter flag not cleared by write one");

    AST_ZERO_KEEPS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_hit(access_wr, paddr_i, FLAG_OFS) && !pwdata_i[FLG_DFS] && flag_reg[FLG_DFS]
        |=> flag_reg[FLG_DFS])
        else $error("zero write disturbed a flag");

    AST_MC_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.cmp_match[0] |=> flag_reg[FLG_MC])
        else $error("channel flag not set after match");

    AST_MC_READ_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.cc_read[1] && evt_i.capture_mode[1] && !evt_i.capture_valid[1]
        && !evt_i.cmp_match[1] |=> !flag_reg[FLG_MC + 1])
        else $error("capture read did not clear channel flag");

    AST_ERR_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.capture_valid[1] && flag_reg[FLG_MC + 1] |=> flag_reg[FLG_ERR])
        else $error("error flag not set on capture overrun");

    AST_SOFT_FAULT_FIRST_FLAG_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.fault_event[0] |=> flag_reg[FLG_FAULT] && status_reg[ST_FAULT])
        else $error("soft fault first flag not set");

    AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_o == |(flag_reg & irq_en_reg & FLAG_MASK))
        else $error("interrupt request mismatch");

    AST_EN_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_hit(access_wr, paddr_i, IRQ_EN_SET_OFS) && pwdata_i[FLG_OVF]
        |=> irq_en_reg[FLG_OVF] ##1 irq_en_reg[FLG_OVF] || $past(access_wr))
        else $error("enable set write lost");

    AST_STOP_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.count_step && !evt_i.stop_cmd && !evt_i.update |=> !status_reg[ST_STOP])
        else $error("stopped bit not cleared on step");

    AST_PERIOD_BUFFER_VALID_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.buf_write[2] |=> status_reg[ST_BUFV + 2])
        else $error("period buffer valid not set");

    // Write-one clear while the flag's own cause stays quiet, so set-wins is not tripped
    sequence s_quiet_w1c(int b, logic cause);
        s_flag_w1c(b) ##0 !cause;
    endsequence

    // Per-channel checks: the same rules hold on every channel
    for (genvar ch = 0; ch < 4; ch++) begin : g_ch_chk
        AST_MC_CAP_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            evt_i.capture_valid[ch] |=> flag_reg[FLG_MC + ch])
            else $error("channel flag not set after capture");

        AST_MC_W1C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            s_quiet_w1c(FLG_MC + ch, evt_i.cmp_match[ch] || evt_i.capture_valid[ch])
            |=> !flag_reg[FLG_MC + ch])
            else $error("channel flag not cleared by write one");

        AST_CHANNEL_BUFFER_VALID_CAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            evt_i.capture_valid[ch] && evt_i.capture_mode[ch]
            |=> status_reg[ST_CHANNEL_BUFFER_VALID + ch])
            else $error("capture buffer valid not set");

        AST_CHANNEL_BUFFER_VALID_READ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            evt_i.cc_read[ch] && evt_i.capture_mode[ch] && !evt_i.capture_valid[ch]
            |=> !status_reg[ST_CHANNEL_BUFFER_VALID + ch])
            else $error("capture buffer valid not cleared by read");

        // Read path carries the level seen at the setup edge
        AST_CMP_READ: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            setup_ph && !pwrite_i && (paddr_i == STATUS_OFS)
            |=> prdata_o[ST_CMP + ch] == $past(evt_i.compare_output_level[ch]))
            else $error("status read lost a compare level");
    end

    // Per-fault checks; index 0 is the soft first input, index 3 hard one
    for (genvar f = 0; f < 4; f++) begin : g_fault_chk
        AST_FAULT_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            evt_i.fault_event[f] |=> flag_reg[FLG_FAULT + f])
            else $error("fault flag not set after fault");

        AST_FAULT_W1C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            s_quiet_w1c(FLG_FAULT + f, evt_i.fault_event[f])
            |=> !flag_reg[FLG_FAULT + f])
            else $error("fault flag not cleared by write one");

        // Two flops of latency before the status input bit follows the pin
        AST_FAULT_IN_HI: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            fault_pin_i[f] [*2] |=> fault_in_reg[f])
            else $error("fault input status missed a high pin");

        AST_FAULT_IN_LO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            !fault_pin_i[f] [*2] |=> !fault_in_reg[f])
            else $error("fault input status missed a low pin");
    end

    AST_DFS_W1C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_quiet_w1c(FLG_DFS, evt_i.debug_fault) |=> !flag_reg[FLG_DFS])
        else $error("debug fault flag not cleared by write one");

    // Ramp change seen against the previous sample, not the design's own detector
    AST_UFS_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        EXTENDED && evt_i.lock_update && (evt_i.ramp_phase != $past(evt_i.ramp_phase))
        |=> flag_reg[FLG_UFS])
        else $error("update fault flag not set");

    AST_OVF_W1C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_quiet_w1c(FLG_OVF, evt_i.overflow) |=> !flag_reg[FLG_OVF])
        else $error("overflow flag not cleared by write one");

    AST_TRG_W1C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_quiet_w1c(FLG_TRG, evt_i.retrigger) |=> !flag_reg[FLG_TRG])
        else $error("retrigger flag not cleared by write one");

    AST_STOP_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_i.stop_cmd || (evt_i.update && evt_i.oneshot) |=> status_reg[ST_STOP])
        else $error("stopped bit not set on halt");

    AST_PERIOD_BUFFER_VALID_W1C: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wr_hit(access_wr, paddr_i, STATUS_OFS) && pwdata_i[ST_BUFV + 2] && !evt_i.buf_write[2]
        |=> !status_reg[ST_BUFV + 2])
        else $error("period buffer valid not cleared by write one");

    // Software relies on busy being up right after any status access
    AST_BUSY_START: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        psel_i && penable_i && (paddr_i == STATUS_OFS) |=> busy_cnt_reg != 2'd0)
        else $error("sync busy not raised after status access");

endmodule : pti_irq_status

`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the timer interrupt-flag and status bank
`timescale 1ns/100ps
`default_nettype none

module tb;
    import pti_pkg::*;
    logic ref_clk_i;
    logic rst_i;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o, err;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd, rnd;
    logic [3:0] fault_pin_i;
    pti_evt_t evt_i, lv, p;
    int err_count = 0;
    int total_checks = 0;

    pti_irq_status i_dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .evt_i(evt_i),
        .fault_pin_i(fault_pin_i), .irq_o(irq_o)
    );

    // 250 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // Repeatable stimulus source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Table entry k: which event pulse, and which flag it raises
    function automatic pti_evt_t pulse_of(input int k);
        pti_evt_t e;
        e = '0;
        case (k)
            0: e.overflow = 1'b1;
            1: e.retrigger = 1'b1;
            2: e.counter_event = 1'b1;
            3: e.debug_fault = 1'b1;
            4, 5, 6, 7: e.fault_event[k - 4] = 1'b1;
            default: e.cmp_match[k - 8] = 1'b1;
        endcase
        return e;
    endfunction : pulse_of

    function automatic logic [31:0] bit_of(input int k);
        if (k < 3) return 32'h1 << k;
        if (k == 3) return 32'h800;
        return 32'h1 << (k + 8);
    endfunction : bit_of

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 16) begin
            err_count++;
            stop_test();
        end
    endtask : apb

    // Levels change alone; pulses ride on top of them for one cycle
    task automatic setlv();
        @(posedge ref_clk_i);
        evt_i <= lv;
    endtask : setlv

    task automatic fire(input pti_evt_t e);
        @(posedge ref_clk_i);
        evt_i <= pti_evt_t'(lv | e);
        @(posedge ref_clk_i);
        evt_i <= lv;
    endtask : fire

    // Main sequence
    initial begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        evt_i = '0;
        lv = '0;
        fault_pin_i = 4'h0;
        rnd = 32'd72;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        apb(1'b0, FLAG_OFS, 32'h0);
        check(rd, 32'h0000_0000);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd, 32'h0000_0001);
        // Busy must drop in bounded time after a status access
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, SYNC_BUSY_OFS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        check({31'h0, rd[0]}, 32'h0);
        p = '0;
        p.count_step = 1'b1;
        fire(p);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h1, 32'h0);
        // Halt by stop command, then by one-shot update
        p = '0;
        p.stop_cmd = 1'b1;
        fire(p);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h1, 32'h1);
        p.stop_cmd = 1'b0;
        p.count_step = 1'b1;
        fire(p);
        p = '0;
        p.update = 1'b1;
        p.oneshot = 1'b1;
        fire(p);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h1, 32'h1);
        // Every flag source except error and update fault: set, survive a zero write, clear on one
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(rnd);
            apb(1'b1, IRQ_EN_SET_OFS, bit_of(k));
            apb(1'b0, IRQ_EN_SET_OFS, 32'h0);
            check(rd, bit_of(k));
            fire(pulse_of(k));
            apb(1'b0, FLAG_OFS, 32'h0);
            check(rd, bit_of(k));
            check({31'h0, irq_o}, 32'h1);
            apb(1'b1, FLAG_OFS, rnd & ~bit_of(k));
            apb(1'b0, FLAG_OFS, 32'h0);
            check(rd, bit_of(k));
            apb(1'b1, FLAG_OFS, bit_of(k));
            apb(1'b0, FLAG_OFS, 32'h0);
            check(rd, 32'h0);
            check({31'h0, irq_o}, 32'h0);
            apb(1'b1, IRQ_EN_CLR_OFS, bit_of(k));
        end
        // Capture into a still-flagged channel, then auto-clear on read
        lv.capture_mode[1] = 1'b1;
        setlv();
        p = '0;
        p.cmp_match[1] = 1'b1;
        fire(p);
        p = '0;
        p.capture_valid[1] = 1'b1;
        fire(p);
        apb(1'b0, FLAG_OFS, 32'h0);
        check(rd, 32'h0002_0008);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h0002_0000, 32'h0002_0000);
        p = '0;
        p.cc_read[1] = 1'b1;
        fire(p);
        apb(1'b0, FLAG_OFS, 32'h0);
        check(rd, 32'h0000_0008);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h0002_0000, 32'h0);
        apb(1'b1, FLAG_OFS, 32'h8);
        // Ramp change while updates are locked
        lv.lock_update = 1'b1;
        setlv();
        lv.ramp_phase = 1'b1;
        setlv();
        apb(1'b0, FLAG_OFS, 32'h0);
        check(rd, 32'h0000_0400);
        apb(1'b1, FLAG_OFS, 32'h400);
        // Period buffer valid: set by write, cleared by one
        p = '0;
        p.buf_write[2] = 1'b1;
        fire(p);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h80, 32'h80);
        apb(1'b1, STATUS_OFS, 32'h80);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd & 32'h80, 32'h0);
        // Random compare levels and fault pins show in status
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            lv.compare_output_level = rnd[3:0];
            setlv();
            fault_pin_i <= rnd[7:4];
            repeat (3) @(posedge ref_clk_i);
            apb(1'b0, STATUS_OFS, 32'h0);
            check({28'h0, rd[27:24]}, {28'h0, rnd[3:0]});
            check({28'h0, rd[11:8]}, {28'h0, rnd[7:4]});
        end
        // Unmapped address is refused
        apb(1'b0, 8'h10, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        stop_test();
    end
endmodule : tb

`default_nettype wire
